// ### rtl/i2cm_collision_brg.sv
// Purpose: repeated start and stop sequencing with collision checks, baud counter, registers
// Assumes: open-drain lines, oe high pulls the line low; AXI4-Lite master keeps the protocol
// Notes: flags are sticky, read of the flag register clears, a new set wins over that clear
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module i2cm_collision_brg
  import i2cm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_oe,
  output logic sda_o,
  output logic irq
);
  i2cm_line_s meta_q, line_q; // line_q is the only stage that logic reads
  i2cm_line_s drv_q; // drive enables, high pulls the line low
  i2cm_state_e st_q, st_d;
  logic [7:0] reload_q, buffer_q, ctl1_q, ctl2_q, flag_q, mask_q;
  logic [7:0] brg_q;
  logic brg_run_q, div_q, stop_seen_q;
  logic tick, expire, brg_load, coll, done, buf_start;
  logic drv_scl_d, drv_sda_d, stop_ok;
  logic [4:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q, w_have_q, wr_fire, rd_fire;
  logic [7:0] rd_val;
  logic rd_hit;

  // two-stage synchroniser for the open-drain lines
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= '{scl: 1'b1, sda: 1'b1};
      line_q <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      meta_q <= '{scl: scl_i, sda: sda_i};
      line_q <= meta_q;
    end
  end

  // tick divider restarts on every load so each count has a fixed length
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_q <= 1'b0;
    end else if (brg_load) begin
      div_q <= 1'b0;
    end else if (brg_run_q) begin
      div_q <= ~div_q;
    end
  end
  assign tick = brg_run_q && div_q; // one pulse per TICK_DIV cycles
  assign expire = tick && (brg_q == 8'h00); // RULE_17

  // baud counter: reload, count down, stop by itself at expiry unless reloaded
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      brg_q <= 8'h00;
      brg_run_q <= 1'b0;
    end else if (brg_load) begin
      brg_q <= reload_q; // RULE_10
      brg_run_q <= 1'b1;
    end else if (coll || expire) begin
      brg_run_q <= 1'b0; // RULE_12
    end else if (tick) begin
      brg_q <= brg_q - 8'h01; // RULE_17
    end
  end

  // sequence decisions; expiries in ST_RS_HOLD and ST_SP_CNT reload at once, ST_RS_LOAD waits for the clock high
  always_comb begin
    st_d = st_q;
    brg_load = 1'b0;
    coll = 1'b0;
    done = 1'b0;
    drv_scl_d = drv_q.scl;
    drv_sda_d = drv_q.sda;
    case (st_q)
      ST_IDLE: begin
        if (ctl2_q[CTL2_RS_BIT]) begin
          drv_sda_d = 1'b0; // RULE_03
          brg_load = 1'b1; // RULE_03
          st_d = ST_RS_LOAD;
        end else if (ctl2_q[CTL2_STOP_BIT]) begin
          drv_sda_d = 1'b1; // RULE_07
          st_d = ST_SP_LOW;
        end else if (buf_start) begin
          brg_load = 1'b1; // RULE_11
        end
      end
      ST_RS_LOAD: begin
        if (expire) begin
          drv_scl_d = 1'b0; // RULE_03
          st_d = ST_RS_SCLW;
        end
      end
      ST_RS_SCLW: begin
        if (line_q.scl) begin
          if (!line_q.sda) begin
            coll = 1'b1; // RULE_01
          end else begin
            brg_load = 1'b1; // RULE_04
            st_d = ST_RS_HOLD;
          end
        end
      end
      ST_RS_HOLD: begin
        // data falling here is another master's start, not a collision
        if (!line_q.scl) begin
          coll = 1'b1; // RULE_02 RULE_05
        end else if (expire) begin
          drv_sda_d = 1'b1; // RULE_06
          brg_load = 1'b1; // RULE_06
          st_d = ST_RS_LOW;
        end
      end
      ST_RS_LOW: begin
        if (expire) begin
          drv_scl_d = 1'b1; // RULE_06
          done = 1'b1;
          st_d = ST_IDLE;
        end
      end
      ST_SP_LOW: begin
        if (!line_q.sda) begin
          drv_scl_d = 1'b0; // RULE_07
          st_d = ST_SP_SCLW;
        end
      end
      ST_SP_SCLW: begin
        if (line_q.scl) begin
          brg_load = 1'b1; // RULE_07
          st_d = ST_SP_CNT;
        end
      end
      ST_SP_CNT: begin
        if (!line_q.scl) begin
          coll = 1'b1; // RULE_09
        end else if (expire) begin
          drv_sda_d = 1'b0;
          brg_load = 1'b1;
          st_d = ST_SP_REL;
        end
      end
      ST_SP_REL: begin
        if (expire) begin
          if (!line_q.sda) begin
            coll = 1'b1; // RULE_08
          end else begin
            done = 1'b1;
            st_d = ST_IDLE;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (coll) begin
      st_d = ST_IDLE; // RULE_15
      brg_load = 1'b0;
      drv_scl_d = 1'b0; // RULE_16
      drv_sda_d = 1'b0; // RULE_16
    end
  end
  assign stop_ok = (st_q == ST_SP_REL) && done;

  // sequencer state, line drivers and stop detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      drv_q <= '{scl: 1'b0, sda: 1'b0};
      stop_seen_q <= 1'b0;
    end else begin
      st_q <= st_d;
      drv_q <= '{scl: drv_scl_d, sda: drv_sda_d};
      if (stop_ok) begin
        stop_seen_q <= 1'b1;
      end else if (st_q != ST_IDLE || !ctl1_q[CTL1_EN_BIT]) begin
        stop_seen_q <= 1'b0;
      end
    end
  end

  // open-drain pins only ever pull low; oe follows the drive flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= drv_scl_d;
      sda_oe <= drv_sda_d;
    end
  end

  // write path: address and data taken in either order, one write at a time
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= OFS_IRQ_EN) ? RESP_OKAY
                                                                           : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // buffer writes start the counter only while idle and enabled in a master mode
  assign buf_start = wr_fire && wstrb_q[0] && awaddr_q == OFS_BUFFER && st_q == ST_IDLE
                     && ctl1_q[CTL1_EN_BIT]
                     && (ctl1_q[3:0] == MODE_I2C_MASTER || ctl1_q[3:0] == MODE_SPI_MASTER);

  // software registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reload_q <= RELOAD_RESET;
      buffer_q <= 8'h00;
      ctl1_q <= 8'h00;
      mask_q <= 8'h00;
    end else if (wr_fire && wstrb_q[0]) begin
      case (awaddr_q)
        OFS_RELOAD: reload_q <= wdata_q[7:0]; // RULE_10
        OFS_BUFFER: buffer_q <= wdata_q[7:0];
        OFS_CTRL_ONE: ctl1_q <= wdata_q[7:0];
        OFS_IRQ_EN: mask_q <= wdata_q[7:0] & IRQ_IMPL_MASK;
        default: begin
        end
      endcase
    end
  end

  // request bits: software sets them while idle in two-wire master mode, hardware clears
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl2_q <= 8'h00;
    end else if (coll || done) begin
      ctl2_q[CTL2_RS_BIT] <= 1'b0; // RULE_16
      ctl2_q[CTL2_STOP_BIT] <= 1'b0; // RULE_16
    end else if (wr_fire && wstrb_q[0] && awaddr_q == OFS_CTRL_TWO && st_q == ST_IDLE
                 && ctl1_q[CTL1_EN_BIT] && ctl1_q[3:0] == MODE_I2C_MASTER) begin
      ctl2_q <= wdata_q[7:0] & 8'h06; // start, ack, receive live elsewhere
    end
  end

  // read path: data captured at the address handshake, one read at a time
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFS_RELOAD: rd_val = reload_q;
      OFS_BUFFER: rd_val = buffer_q;
      OFS_CTRL_ONE: rd_val = ctl1_q;
      OFS_CTRL_TWO: rd_val = ctl2_q;
      OFS_STATUS: rd_val = {3'h0, stop_seen_q, 1'b0, st_q != ST_IDLE, 2'h0};
      OFS_IRQ_FLAG: rd_val = flag_q;
      OFS_IRQ_EN: rd_val = mask_q;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_val};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // sticky flags: read clears, a same-cycle event wins over the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_q <= 8'h00;
    end else begin
      if (rd_fire && s_axi_araddr == OFS_IRQ_FLAG) begin
        flag_q <= 8'h00;
      end
      if (coll) begin
        flag_q[IRQ_COLL_BIT] <= 1'b1; // RULE_15
      end
      if (done) begin
        flag_q[IRQ_DONE_BIT] <= 1'b1;
      end
    end
  end

  // interrupt level from the registered flags under mask
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_q & mask_q);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_rs_low_data;
    (st_q == ST_RS_SCLW) && line_q.scl && !line_q.sda |=> flag_q[IRQ_COLL_BIT]
      && st_q == ST_IDLE;
  endproperty
  a_rs_low_data: assert property (p_rs_low_data) else $error("rs data low not flagged"); // RULE_01
  property p_rs_scl_fall;
    (st_q == ST_RS_HOLD) && !line_q.scl |=> flag_q[IRQ_COLL_BIT] && !scl_oe && !sda_oe;
  endproperty
  a_rs_scl_fall: assert property (p_rs_scl_fall) else $error("rs clock fall not flagged"); // RULE_05
  property p_rs_begin;
    (st_q == ST_IDLE) && ctl2_q[CTL2_RS_BIT] |=> !sda_oe && brg_q == reload_q && brg_run_q;
  endproperty
  a_rs_begin: assert property (p_rs_begin) else $error("rs did not load counter"); // RULE_03
  property p_rs_sda_fall;
    (st_q == ST_RS_HOLD) && line_q.scl && !line_q.sda |=> st_q == ST_RS_HOLD
      || st_q == ST_RS_LOW;
  endproperty
  a_rs_sda_fall: assert property (p_rs_sda_fall) else $error("data fall flagged"); // RULE_04
  property p_rs_finish;
    (st_q == ST_RS_LOW) && expire |=> scl_oe && sda_oe && st_q == ST_IDLE;
  endproperty
  a_rs_finish: assert property (p_rs_finish) else $error("rs end wrong"); // RULE_06
  property p_sp_data_low;
    (st_q == ST_SP_REL) && expire && !line_q.sda |=> flag_q[IRQ_COLL_BIT];
  endproperty
  a_sp_data_low: assert property (p_sp_data_low) else $error("stop data low missed"); // RULE_08
  property p_sp_scl_low;
    (st_q == ST_SP_CNT) && !line_q.scl |=> flag_q[IRQ_COLL_BIT] && !ctl2_q[CTL2_STOP_BIT];
  endproperty
  a_sp_scl_low: assert property (p_sp_scl_low) else $error("stop clock low missed"); // RULE_09
  property p_half_period;
    brg_load && !coll |=> (brg_q == $past(reload_q)) && !div_q;
  endproperty
  a_half_period: assert property (p_half_period) else $error("reload not taken"); // RULE_13
  property p_idle_hold;
    (st_q == ST_IDLE) ##1 (st_q == ST_IDLE) |-> $stable(scl_oe);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("clock moved while idle"); // RULE_12
  property p_irq;
    ##1 irq == |($past(flag_q) & $past(mask_q));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  c_rs_done: cover property ((st_q == ST_RS_LOW) && expire);
  c_sp_done: cover property (stop_ok);
  c_coll: cover property (coll ##1 irq);
  c_buf_start: cover property (buf_start ##[1:600] expire);
endmodule

// ### rtl/i2cm_pkg.sv
// Purpose: constants, states and carriers of the two-wire master collision/baud block
// Assumes: 32-bit AXI4-Lite register access, one 100 MHz clock
// Notes: register offsets are byte addresses, one aligned word each
// Contract
// RULE_01 - repeated start: data low when clock rises means collision
// RULE_02 - repeated start: clock falls before data driven low means collision
// RULE_03 - repeated start: release data, load counter, expiry releases clock, then sample data
// RULE_04 - data high: reload and go on; data falling meanwhile is no collision
// RULE_05 - clock falling before expiry with data not yet driven means collision
// RULE_06 - both high at expiry: drive data low, reload, next expiry drives clock low
// RULE_07 - stop: hold data low, then release clock, when clock high load and count
// RULE_08 - stop: after expiry sample data, low means collision
// RULE_09 - stop: clock low before data released means collision
// RULE_10 - counter reloads from software register, serves two-wire and SPI master modes
// RULE_11 - write to shift buffer starts the counter counting down
// RULE_12 - when operation ends counter stops and clock pin keeps its level
// RULE_13 - reload twice per bus period, bus clock is oscillator over four times reload+1
// RULE_14 - software must not use reload values zero, one or two for two-wire
// RULE_15 - any collision sets collision flag and returns port to idle
// RULE_16 - collision aborts running condition, releases lines, clears its request bit
// RULE_17 - eight-bit down counter on a divided tick, expiry at zero
package i2cm_pkg;
  localparam logic [4:0] OFS_RELOAD = 5'h00; // baud_reload_value
  localparam logic [4:0] OFS_BUFFER = 5'h04; // serial_shift_buffer
  localparam logic [4:0] OFS_CTRL_ONE = 5'h08; // serial_control_one
  localparam logic [4:0] OFS_CTRL_TWO = 5'h0c; // serial_control_two
  localparam logic [4:0] OFS_STATUS = 5'h10; // serial_status
  localparam logic [4:0] OFS_IRQ_FLAG = 5'h14; // peripheral_irq_flag_two, read clears
  localparam logic [4:0] OFS_IRQ_EN = 5'h18; // peripheral_irq_enable_two
  localparam int CTL1_EN_BIT = 5;
  localparam int CTL2_STOP_BIT = 2; // stop_request
  localparam int CTL2_RS_BIT = 1; // repeated_start_request
  localparam int STAT_STOP_BIT = 4;
  localparam int STAT_BUSY_BIT = 2;
  localparam int IRQ_COLL_BIT = 3; // bus_collision_flag
  localparam int IRQ_DONE_BIT = 0; // operation complete
  localparam logic [7:0] IRQ_IMPL_MASK = 8'h09;
  localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
  localparam logic [3:0] MODE_SPI_MASTER = 4'ha;
  localparam logic [7:0] RELOAD_RESET = 8'h09;
  localparam int CLK_SYS_MHZ = 100;
  localparam int OSC_MHZ = 100; // bus clock formula uses the system clock as oscillator
  localparam int TICK_DIV = (CLK_SYS_MHZ * 2) / OSC_MHZ; // two clk_sys cycles per counter tick
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_RS_LOAD = 9'h002,
    ST_RS_SCLW = 9'h004,
    ST_RS_HOLD = 9'h008,
    ST_RS_LOW = 9'h010,
    ST_SP_LOW = 9'h020,
    ST_SP_SCLW = 9'h040,
    ST_SP_CNT = 9'h080,
    ST_SP_REL = 9'h100
  } i2cm_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cm_line_s;
endpackage

// ### test/i2cm_bus_partner.sv
// Purpose: other masters and slaves on the shared two-wire bus, pull-ups on both lines
// Assumes: open-drain wiring, so any party pulling a line low wins
// Notes: can stretch the clock after the master lets go of it, to answer slowly
`timescale 1ns/1ps
module i2cm_bus_partner (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic pull_scl,
  input wire logic pull_sda,
  input wire logic [7:0] stretch,
  output logic scl_line,
  output logic sda_line
);
  logic [7:0] hold_q;
  logic scl_oe_q;
  logic release_now;
  // stretch counts from the master's release of the clock line
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_q <= 8'h00;
      scl_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= scl_oe;
      if (release_now) begin
        hold_q <= stretch;
      end else if (hold_q != 8'h00) begin
        hold_q <= hold_q - 8'h01;
      end
    end
  end
  // no gap cycle between the release and the start of the stretch
  assign release_now = scl_oe_q && !scl_oe;
  assign scl_line = !(scl_oe || pull_scl || hold_q != 8'h00 || (release_now && stretch != 8'h00));
  assign sda_line = !(sda_oe || pull_sda);
endmodule

// ### test/i2c_master_collision_brg_tb.sv
// Purpose: self-checking bench for repeated start, stop, collisions and the baud counter
// Assumes: reload 9 during bus sequences, so one count is 20 clk_sys cycles
// Notes: ready and valid are looked at on the falling edge, acted on at the next rising edge
`timescale 1ns/1ps
module i2c_master_collision_brg_tb;
  import i2cm_pkg::*;
  localparam int T = 20;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic scl_line, sda_line, scl_o, scl_oe, sda_o, sda_oe, irq;
  logic pull_scl = 1'b0, pull_sda = 1'b0;
  logic [7:0] stretch = 8'h00;
  logic [7:0] seed = 8'h54;
  int num_errors = 0, checks_done = 0, cycles = 0, c;

  always #5 clk_sys = ~clk_sys;

  i2cm_collision_brg DUT (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line), .sda_oe(sda_oe),
    .sda_o(sda_o), .irq(irq));

  i2cm_bus_partner u_bus (
    .clk_sys(clk_sys), .rst(rst), .scl_oe(scl_oe), .sda_oe(sda_oe), .pull_scl(pull_scl),
    .pull_sda(pull_sda), .stretch(stretch), .scl_line(scl_line), .sda_line(sda_line));

  // verdict in one place
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // address and data offered together, each dropped once taken
  task automatic axi_write(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    n = 0;
    r = 2'h3;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = tb ? s_axi_bresp : r;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      n++;
    end while (!tb && n < 100);
    if (!tb) num_errors++;
  endtask

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int n;
    n = 0;
    d = 32'hffffffff;
    r = 2'h3;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = tr ? s_axi_rdata : d;
      r = tr ? s_axi_rresp : r;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      n++;
    end while (!tr && n < 100);
    if (!tr) num_errors++;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    axi_write(a, d, rsp);
    chk("bresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  task automatic rdchk(input string what, input logic [4:0] a, input logic [31:0] exp);
    axi_read(a, rd, rsp);
    chk(what, rd, exp);
  endtask

  // sel 0 clock enable, 1 data enable, 2 interrupt; n counts falling edges
  task automatic wait_pin(input int sel, input logic v, output int n);
    logic p;
    n = 0;
    do begin
      @(negedge clk_sys);
      p = (sel == 0) ? scl_oe : (sel == 1) ? sda_oe : irq;
      n++;
    end while (p !== v && n < 1000);
    if (p !== v) num_errors++;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      axi_read(OFS_STATUS, rd, rsp);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 200);
    if (rd[STAT_BUSY_BIT] !== 1'b0) num_errors++;
  endtask

  // after a collision: lines free, request bits gone, flag sticky until read
  task automatic coll_check(input logic irq_exp);
    wait_idle();
    chk("scl_oe", {31'h0, scl_oe}, 32'h0);
    chk("sda_oe", {31'h0, sda_oe}, 32'h0);
    chk("pins_o", {30'h0, scl_o, sda_o}, 32'h0);
    chk("irq", {31'h0, irq}, {31'h0, irq_exp});
    rdchk("ctl2", OFS_CTRL_TWO, 32'h0);
    rdchk("flags", OFS_IRQ_FLAG, 32'h8);
    rdchk("flags_clr", OFS_IRQ_FLAG, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("irq_clr", {31'h0, irq}, 32'h0);
  endtask

  // clean repeated start, another party dips the data line during the hold count
  task automatic rs_clean();
    wr(OFS_CTRL_TWO, 8'h02);
    wait_pin(0, 1'b0, c);
    // land the dip inside the hold count, one full count after the load
    repeat (T + 6) @(posedge clk_sys);
    pull_sda <= 1'b1;
    repeat (3) @(posedge clk_sys);
    pull_sda <= 1'b0;
    wait_pin(1, 1'b1, c);
    wait_pin(0, 1'b1, c);
    chk("rs_hold_cycles", {31'h0, c >= T - 1 && c <= T + 1}, 32'h1);
    wait_idle();
    rdchk("rs_flags", OFS_IRQ_FLAG, 32'h1);
    rdchk("rs_ctl2", OFS_CTRL_TWO, 32'h0);
  endtask

  // another party pulls the clock low while the count runs
  task automatic coll_scl(input logic [7:0] ctl);
    wr(OFS_CTRL_TWO, ctl);
    wait_pin(0, 1'b0, c);
    repeat (6) @(posedge clk_sys);
    pull_scl <= 1'b1;
    wait_pin(2, 1'b1, c);
    @(posedge clk_sys);
    pull_scl <= 1'b0;
    coll_check(1'b1);
  endtask

  // hang guard, far above the length of the sequence below
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk("reload_rst", OFS_RELOAD, {24'h0, RELOAD_RESET});
    rdchk("ctl1_rst", OFS_CTRL_ONE, 32'h0);
    axi_read(5'h1c, rd, rsp);
    chk("unmapped_rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_write(5'h1c, 8'hff, rsp);
    chk("unmapped_bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    // random readback of reload and mask
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(OFS_RELOAD, seed);
      rdchk("reload_rw", OFS_RELOAD, {24'h0, seed});
      wr(OFS_IRQ_EN, seed);
      rdchk("mask_rw", OFS_IRQ_EN, {24'h0, seed & IRQ_IMPL_MASK});
    end
    // a write with byte lane 0 disabled leaves the register alone
    s_axi_wstrb <= 4'h0;
    wr(OFS_RELOAD, 8'h33);
    s_axi_wstrb <= 4'hf;
    rdchk("reload_nostrb", OFS_RELOAD, {24'h0, seed});
    wr(OFS_RELOAD, 8'h09);
    wr(OFS_CTRL_TWO, 8'h02);
    rdchk("ctl2_disabled", OFS_CTRL_TWO, 32'h0);
    // buffer write in both master modes runs one count, pins untouched
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CTRL_ONE, {4'h2, (m == 1) ? MODE_SPI_MASTER : MODE_I2C_MASTER});
      seed = lfsr(seed);
      wr(OFS_BUFFER, seed);
      repeat (3 * T) @(posedge clk_sys);
      chk("buf_pins", {30'h0, scl_oe, sda_oe}, 32'h0);
      axi_read(OFS_IRQ_FLAG, rd, rsp);
    end
    wr(OFS_CTRL_ONE, {4'h2, MODE_I2C_MASTER});
    rs_clean();
    // stop with the partner stretching the clock
    stretch <= 8'h05;
    wr(OFS_CTRL_TWO, 8'h04);
    wait_pin(1, 1'b1, c);
    wait_pin(0, 1'b0, c);
    wait_pin(1, 1'b0, c);
    chk("sp_count", {31'h0, c >= T + 5 && c <= T + 10}, 32'h1);
    wait_idle();
    rdchk("sp_status", OFS_STATUS, 32'h10);
    rdchk("sp_flags", OFS_IRQ_FLAG, 32'h1);
    stretch <= 8'h00;
    wr(OFS_IRQ_EN, 8'h08);
    rs_clean();
    coll_scl(8'h02);
    // data held low when the clock rises in a repeated start
    wr(OFS_CTRL_TWO, 8'h02);
    pull_sda <= 1'b1;
    wait_pin(2, 1'b1, c);
    @(posedge clk_sys);
    pull_sda <= 1'b0;
    coll_check(1'b1);
    // data held low after the stop count, interrupt masked
    wr(OFS_IRQ_EN, 8'h00);
    wr(OFS_CTRL_TWO, 8'h04);
    pull_sda <= 1'b1;
    wait_idle();
    pull_sda <= 1'b0;
    coll_check(1'b0);
    wr(OFS_IRQ_EN, 8'h08);
    rs_clean();
    coll_scl(8'h04);
    end_sim();
  end
endmodule
